// ---- design/dual_encoder_counter_limit_switch.sv ----
// dual encoder counter with preset and four window limit outputs, APB slave
//
// Behaviour
// - counter one mode from config bits 2..0, counter two from 5..3
// - mode codes: 000 x1, 001 x2, 010 x4, 100 rise+dir, 101 both+dir
// - x1 counts one per period, rising edges of A only
// - x2 counts two per period, both edges of A
// - x4 counts four per period, both edges of A and B
// - quadrature direction comes from the A/B phase relation
// - rise+dir: A rising adds one if B high, subtracts if low
// - both+dir: each A edge adds one if B high, subtracts if low
// - preset mode of counter one from bits 7..6, counter two 9..8
// - preset codes: 00 level, 01 rising, 10 falling, 11 high and A rising
// - limit on and off values are 24 bits wide
// - four limit outputs, two per counter, each from its own setpoint pair
// - output on while on value <= count < off value
// - status bits 3..0 mirror the four limit outputs
// - preset event loads the reload value, counting then continues
// - reload value is 24 bits wide
// - level preset holds count at reload value, no counting meanwhile
// - high-and-edge preset reloads per A rise, holds while preset high
//
// The APB register port was decided locally.
`timescale 1ns/1ps
module dual_encoder_counter_limit_switch (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [enc_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [enc_pkg::DATA_W-1:0] pwdata_i,
    input wire logic [enc_pkg::STRB_W-1:0] pstrb_i,
    output logic [enc_pkg::DATA_W-1:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // encoder and preset pins, index 0 is counter one
    input wire logic [enc_pkg::CHANNELS-1:0] enc_a_i,
    input wire logic [enc_pkg::CHANNELS-1:0] enc_b_i,
    input wire logic [enc_pkg::CHANNELS-1:0] preset_i,
    // limit switch outputs, bit order as the status word
    output logic [enc_pkg::LIMITS-1:0] limit_o
);

    // register file
    logic [enc_pkg::VAL_W-1:0] on_reg [enc_pkg::LIMITS];
    logic [enc_pkg::VAL_W-1:0] off_reg [enc_pkg::LIMITS];
    logic [enc_pkg::VAL_W-1:0] reload_reg [enc_pkg::CHANNELS];
    logic [enc_pkg::CFG_W-1:0] config_reg;

    // live state
    logic [enc_pkg::VAL_W-1:0] count_reg [enc_pkg::CHANNELS];
    logic [enc_pkg::LIMITS-1:0] limit_reg;

    // bus side state
    logic [enc_pkg::DATA_W-1:0] prdata_reg;
    logic pready_reg;
    logic err_reg;

    // combinational bus decode
    logic [enc_pkg::DATA_W-1:0] rd_data;
    logic hit_rw;
    logic hit_ro;
    logic bad_access;
    logic setup_phase;
    logic access_done;
    logic wr_en;

    enc_step_if chan_if [enc_pkg::CHANNELS] ();

    // per channel sampling and step decoding
    for (genvar g = 0; g < enc_pkg::CHANNELS; g++) begin : gen_chan
        enc_pkg::cnt_mode_t cnt_mode;
        enc_pkg::pre_mode_t pre_mode;

        // field extraction from the shared word
        assign cnt_mode = config_reg[enc_pkg::CFG_CNT_LSB[g] +: enc_pkg::CNT_MODE_W];
        assign pre_mode = config_reg[enc_pkg::CFG_PRE_LSB[g] +: enc_pkg::PRE_MODE_W];

        enc_input_sync u_sync (
            .clk_i(clk_i),
            .rst_n_i(rst_n_i),
            .a_i(enc_a_i[g]),
            .b_i(enc_b_i[g]),
            .pre_i(preset_i[g]),
            .s(chan_if[g].sampler)
        );

        enc_step_decode u_decode (
            .cnt_mode_i(cnt_mode),
            .pre_mode_i(pre_mode),
            .d(chan_if[g].decoder)
        );

        // counter: preset wins over a step, hold blocks steps
        always_ff @(posedge clk_i) begin
            if (!rst_n_i) begin
                count_reg[g] <= enc_pkg::VAL_RESET;
            end else if (chan_if[g].load) begin
                count_reg[g] <= reload_reg[g];
            end else if (chan_if[g].hold) begin
                count_reg[g] <= count_reg[g];
            end else if (chan_if[g].step_up) begin
                count_reg[g] <= count_reg[g] + 1'b1;
            end else if (chan_if[g].step_dn) begin
                count_reg[g] <= count_reg[g] - 1'b1;
            end
        end
    end

    // window compare, one cycle behind the count so outputs stay registered
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            limit_reg <= '0;
        end else begin
            for (int k = 0; k < enc_pkg::LIMITS; k++) begin
                // limits 0,1 watch counter one and limits 2,3 counter two
                limit_reg[k] <= (count_reg[k / 2] >= on_reg[k]) &&
                                (count_reg[k / 2] < off_reg[k]);
            end
        end
    end
    assign limit_o = limit_reg;

    // apb phase decode
    assign setup_phase = psel_i & ~penable_i;
    assign access_done = psel_i & penable_i & pready_reg;
    assign wr_en = access_done & pwrite_i & ~err_reg;

    // address decode and read mux
    always_comb begin
        rd_data = '0;
        hit_rw = 1'b0;
        hit_ro = 1'b0;
        for (int k = 0; k < enc_pkg::LIMITS; k++) begin
            if (paddr_i == enc_pkg::word_addr(enc_pkg::IDX_LIMIT_ON[k])) begin
                rd_data = enc_pkg::DATA_W'(on_reg[k]);
                hit_rw = 1'b1;
            end
            if (paddr_i == enc_pkg::word_addr(enc_pkg::IDX_LIMIT_OFF[k])) begin
                rd_data = enc_pkg::DATA_W'(off_reg[k]);
                hit_rw = 1'b1;
            end
        end
        for (int c = 0; c < enc_pkg::CHANNELS; c++) begin
            if (paddr_i == enc_pkg::word_addr(enc_pkg::IDX_RELOAD[c])) begin
                rd_data = enc_pkg::DATA_W'(reload_reg[c]);
                hit_rw = 1'b1;
            end
            if (paddr_i == (enc_pkg::RO_BASE | enc_pkg::word_addr(enc_pkg::IDX_COUNT[c]))) begin
                rd_data = enc_pkg::DATA_W'(count_reg[c]);
                hit_ro = 1'b1;
            end
        end
        if (paddr_i == enc_pkg::word_addr(enc_pkg::IDX_SHARED_CONFIG)) begin
            rd_data = enc_pkg::DATA_W'(config_reg);
            hit_rw = 1'b1;
        end
        if (paddr_i == (enc_pkg::RO_BASE | enc_pkg::word_addr(enc_pkg::IDX_LIMIT_FLAGS))) begin
            rd_data = enc_pkg::DATA_W'(limit_reg);
            hit_ro = 1'b1;
        end
        // writes may only land on writable words; reads on any mapped word
        bad_access = pwrite_i ? ~hit_rw : ~(hit_rw | hit_ro);
    end

    // handshake: answer is prepared in setup so every output is a flop
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pready_reg <= 1'b0;
            err_reg <= 1'b0;
            prdata_reg <= '0;
        end else if (access_done) begin
            pready_reg <= 1'b0;
            err_reg <= 1'b0;
            prdata_reg <= '0;
        end else if (setup_phase) begin
            // read data is a snapshot of the setup cycle
            pready_reg <= 1'b1;
            err_reg <= bad_access;
            prdata_reg <= (pwrite_i | bad_access) ? '0 : rd_data;
        end
    end
    assign pready_o = pready_reg;
    assign pslverr_o = err_reg;
    assign prdata_o = prdata_reg;

    // limit setpoint writes, byte lanes above the value width are dropped
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            for (int k = 0; k < enc_pkg::LIMITS; k++) begin
                on_reg[k] <= enc_pkg::VAL_RESET;
                off_reg[k] <= enc_pkg::VAL_RESET;
            end
        end else if (wr_en) begin
            for (int k = 0; k < enc_pkg::LIMITS; k++) begin
                if (paddr_i == enc_pkg::word_addr(enc_pkg::IDX_LIMIT_ON[k])) begin
                    on_reg[k] <= enc_pkg::VAL_W'(enc_pkg::merge(
                        enc_pkg::DATA_W'(on_reg[k]), pwdata_i, pstrb_i));
                end
                if (paddr_i == enc_pkg::word_addr(enc_pkg::IDX_LIMIT_OFF[k])) begin
                    off_reg[k] <= enc_pkg::VAL_W'(enc_pkg::merge(
                        enc_pkg::DATA_W'(off_reg[k]), pwdata_i, pstrb_i));
                end
            end
        end
    end

    // reload value writes
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            for (int c = 0; c < enc_pkg::CHANNELS; c++) begin
                reload_reg[c] <= enc_pkg::VAL_RESET;
            end
        end else if (wr_en) begin
            for (int c = 0; c < enc_pkg::CHANNELS; c++) begin
                if (paddr_i == enc_pkg::word_addr(enc_pkg::IDX_RELOAD[c])) begin
                    reload_reg[c] <= enc_pkg::VAL_W'(enc_pkg::merge(
                        enc_pkg::DATA_W'(reload_reg[c]), pwdata_i, pstrb_i));
                end
            end
        end
    end

    // shared config write, unused bits forced to zero
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            config_reg <= enc_pkg::CONFIG_RESET;
        end else if (wr_en && paddr_i == enc_pkg::word_addr(enc_pkg::IDX_SHARED_CONFIG)) begin
            config_reg <= enc_pkg::CFG_W'(enc_pkg::merge(
                enc_pkg::DATA_W'(config_reg), pwdata_i, pstrb_i)) & enc_pkg::CFG_USED_MASK;
        end
    end

endmodule // dual_encoder_counter_limit_switch

// ---- design/enc_input_sync.sv ----
// synchroniser and edge detector for one channel's three inputs
`timescale 1ns/1ps
module enc_input_sync (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // raw pins
    input wire logic a_i,
    input wire logic b_i,
    input wire logic pre_i,
    // sampled levels and edges
    enc_step_if.sampler s
);
    logic [2:0] meta_reg;
    logic [2:0] sync_reg;
    logic [2:0] last_reg;

    // first stage feeds only the second stage
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            meta_reg <= 3'h0;
            sync_reg <= 3'h0;
            last_reg <= 3'h0;
        end else begin
            meta_reg <= {pre_i, b_i, a_i};
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    // edges compare two settled samples, so each edge shows for one cycle
    always_comb begin
        s.a = sync_reg[0];
        s.b = sync_reg[1];
        s.pre = sync_reg[2];
        s.a_rise = sync_reg[0] & ~last_reg[0];
        s.a_fall = ~sync_reg[0] & last_reg[0];
        s.b_rise = sync_reg[1] & ~last_reg[1];
        s.b_fall = ~sync_reg[1] & last_reg[1];
        s.pre_rise = sync_reg[2] & ~last_reg[2];
        s.pre_fall = ~sync_reg[2] & last_reg[2];
    end
endmodule // enc_input_sync

// ---- design/enc_pkg.sv ----
// shared constants, types and helpers for the dual encoder counter
package enc_pkg;

    // widths and counts
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned STRB_W = 4;
    localparam int unsigned VAL_W = 24;
    localparam int unsigned CFG_W = 16;
    localparam int unsigned CHANNELS = 2;
    localparam int unsigned LIMITS = 4;
    localparam int unsigned CNT_MODE_W = 3;
    localparam int unsigned PRE_MODE_W = 2;

    // word indices of the writable registers
    localparam logic [7:0] IDX_CH1_LIMIT1_ON = 8'h00;
    localparam logic [7:0] IDX_CH1_LIMIT1_OFF = 8'h02;
    localparam logic [7:0] IDX_CH1_LIMIT2_ON = 8'h04;
    localparam logic [7:0] IDX_CH1_LIMIT2_OFF = 8'h06;
    localparam logic [7:0] IDX_CH2_LIMIT1_ON = 8'h08;
    localparam logic [7:0] IDX_CH2_LIMIT1_OFF = 8'h0A;
    localparam logic [7:0] IDX_CH2_LIMIT2_ON = 8'h0C;
    localparam logic [7:0] IDX_CH2_LIMIT2_OFF = 8'h0E;
    localparam logic [7:0] IDX_CH1_RELOAD = 8'h10;
    localparam logic [7:0] IDX_CH2_RELOAD = 8'h12;
    localparam logic [7:0] IDX_SHARED_CONFIG = 8'h14;

    // word indices of the read-only registers, placed above the readonly base
    localparam logic [7:0] IDX_CH1_COUNT = 8'h00;
    localparam logic [7:0] IDX_CH2_COUNT = 8'h02;
    localparam logic [7:0] IDX_LIMIT_FLAGS = 8'h04;
    localparam logic [ADDR_W-1:0] RO_BASE = 12'h100;

    localparam logic [7:0] IDX_LIMIT_ON [LIMITS] = '{IDX_CH1_LIMIT1_ON, IDX_CH1_LIMIT2_ON,
                                                     IDX_CH2_LIMIT1_ON, IDX_CH2_LIMIT2_ON};
    localparam logic [7:0] IDX_LIMIT_OFF [LIMITS] = '{IDX_CH1_LIMIT1_OFF, IDX_CH1_LIMIT2_OFF,
                                                      IDX_CH2_LIMIT1_OFF, IDX_CH2_LIMIT2_OFF};
    localparam logic [7:0] IDX_RELOAD [CHANNELS] = '{IDX_CH1_RELOAD, IDX_CH2_RELOAD};
    localparam logic [7:0] IDX_COUNT [CHANNELS] = '{IDX_CH1_COUNT, IDX_CH2_COUNT};

    // configuration field positions
    localparam int unsigned CFG_CNT_LSB [CHANNELS] = '{0, 3};
    localparam int unsigned CFG_PRE_LSB [CHANNELS] = '{6, 8};
    localparam logic [CFG_W-1:0] CFG_USED_MASK = 16'h03FF;

    // values after reset
    localparam logic [CFG_W-1:0] CONFIG_RESET = 16'h0000;
    localparam logic [VAL_W-1:0] VAL_RESET = 24'h000000;

    // counting mode and preset mode codes
    typedef logic [CNT_MODE_W-1:0] cnt_mode_t;
    typedef logic [PRE_MODE_W-1:0] pre_mode_t;
    localparam cnt_mode_t MODE_QUAD_X1 = 3'h0;
    localparam cnt_mode_t MODE_QUAD_X2 = 3'h1;
    localparam cnt_mode_t MODE_QUAD_X4 = 3'h2;
    localparam cnt_mode_t MODE_PULSE_RISE = 3'h4;
    localparam cnt_mode_t MODE_PULSE_BOTH = 3'h5;
    localparam pre_mode_t PRE_LEVEL = 2'h0;
    localparam pre_mode_t PRE_RISE = 2'h1;
    localparam pre_mode_t PRE_FALL = 2'h2;
    localparam pre_mode_t PRE_HIGH_AND_EDGE = 2'h3;

    // byte address of a word index
    function automatic logic [ADDR_W-1:0] word_addr(input logic [7:0] idx);
        word_addr = {2'h0, idx, 2'h0};
    endfunction

    // byte-lane merge of a write into an old value
    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_v,
                                                input logic [DATA_W-1:0] new_v,
                                                input logic [STRB_W-1:0] strb);
        merge = old_v;
        for (int i = 0; i < STRB_W; i++) begin
            if (strb[i]) begin
                merge[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
    endfunction

endpackage

// ---- design/enc_step_decode.sv ----
// turns sampled edges into count steps and preset actions for one channel
`timescale 1ns/1ps
module enc_step_decode (
    // mode selection
    input wire enc_pkg::cnt_mode_t cnt_mode_i,
    input wire enc_pkg::pre_mode_t pre_mode_i,
    // sampled inputs in, actions out
    enc_step_if.decoder d
);
    logic up_v;
    logic dn_v;

    // count direction from phase or direction input
    always_comb begin
        up_v = 1'b0;
        dn_v = 1'b0;
        case (cnt_mode_i)
            enc_pkg::MODE_QUAD_X1: begin
                if (d.a_rise) begin
                    up_v = ~d.b;
                    dn_v = d.b;
                end
            end
            enc_pkg::MODE_QUAD_X2, enc_pkg::MODE_QUAD_X4: begin
                if (d.a_rise) begin
                    up_v = ~d.b;
                    dn_v = d.b;
                end
                if (d.a_fall) begin
                    up_v = d.b;
                    dn_v = ~d.b;
                end
                if (cnt_mode_i == enc_pkg::MODE_QUAD_X4) begin
                    if (d.b_rise) begin
                        up_v = up_v | d.a;
                        dn_v = dn_v | ~d.a;
                    end
                    if (d.b_fall) begin
                        up_v = up_v | ~d.a;
                        dn_v = dn_v | d.a;
                    end
                end
            end
            enc_pkg::MODE_PULSE_RISE: begin
                if (d.a_rise) begin
                    up_v = d.b;
                    dn_v = ~d.b;
                end
            end
            enc_pkg::MODE_PULSE_BOTH: begin
                if (d.a_rise | d.a_fall) begin
                    up_v = d.b;
                    dn_v = ~d.b;
                end
            end
            default: begin
                up_v = 1'b0;
                dn_v = 1'b0;
            end
        endcase
        // simultaneous opposing steps cancel rather than pick a side
        d.step_up = up_v & ~dn_v;
        d.step_dn = dn_v & ~up_v;
    end

    // preset trigger selection
    always_comb begin
        d.load = 1'b0;
        d.hold = 1'b0;
        case (pre_mode_i)
            enc_pkg::PRE_LEVEL: begin
                d.load = d.pre;
                d.hold = d.pre;
            end
            enc_pkg::PRE_RISE: d.load = d.pre_rise;
            enc_pkg::PRE_FALL: d.load = d.pre_fall;
            enc_pkg::PRE_HIGH_AND_EDGE: begin
                d.load = d.pre & d.a_rise;
                d.hold = d.pre;
            end
            default: d.load = 1'b0;
        endcase
    end
endmodule // enc_step_decode

// ---- design/enc_step_if.sv ----
// per-channel carrier between input sampling, step decoding and the counter
`timescale 1ns/1ps
interface enc_step_if;
    logic a;
    logic b;
    logic pre;
    logic a_rise;
    logic a_fall;
    logic b_rise;
    logic b_fall;
    logic pre_rise;
    logic pre_fall;
    logic step_up;
    logic step_dn;
    logic load;
    logic hold;

    modport sampler (output a, b, pre, a_rise, a_fall, b_rise, b_fall, pre_rise, pre_fall);
    modport decoder (input a, b, pre, a_rise, a_fall, b_rise, b_fall, pre_rise, pre_fall,
                     output step_up, step_dn, load, hold);
    modport counter (input step_up, step_dn, load, hold);
endinterface

// ---- verif/dual_encoder_counter_limit_switch_props.sv ----
// port checker for the dual encoder counter
`timescale 1ns/1ps
module dual_encoder_counter_limit_switch_props (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // apb
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [enc_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [enc_pkg::DATA_W-1:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // pins
    input wire logic [enc_pkg::CHANNELS-1:0] enc_a_i,
    input wire logic [enc_pkg::CHANNELS-1:0] enc_b_i,
    input wire logic [enc_pkg::CHANNELS-1:0] preset_i,
    input wire logic [enc_pkg::LIMITS-1:0] limit_o
);
    logic [5:0] pins_reg;
    logic [3:0] quiet_reg;

    // cycles since a pin moved or a write; reads leave the limits alone
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pins_reg <= 6'h00;
            quiet_reg <= 4'h0;
        end else begin
            pins_reg <= {enc_a_i, enc_b_i, preset_i};
            if ((psel_i && pwrite_i) || pins_reg != {enc_a_i, enc_b_i, preset_i}) begin
                quiet_reg <= 4'h0;
            end else if (quiet_reg != 4'hF) begin
                quiet_reg <= quiet_reg + 4'h1;
            end
        end
    end

    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence setup_s;
        psel_i && !penable_i;
    endsequence
    sequence settled_s;
        quiet_reg >= 4'h8;
    endsequence

    setup_ready_a: assert property (setup_s |=> pready_o)
        else $error("no ready after setup");
    ready_pulse_a: assert property (pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
    err_ready_a: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    rdata_idle_a: assert property (!pready_o |-> prdata_o == 32'h00000000)
        else $error("read data outside ready");
    bad_align_a: assert property (setup_s ##0 paddr_i[1:0] != 2'h0 |=> pslverr_o)
        else $error("misaligned access not refused");
    ro_write_a: assert property (setup_s ##0 (pwrite_i && paddr_i >= enc_pkg::RO_BASE) |=> pslverr_o)
        else $error("readonly write not refused");
    top_byte_a: assert property (pready_o && !pwrite_i |-> prdata_o[31:24] == 8'h00)
        else $error("read value wider than 24 bits");
    limit_hold_a: assert property (settled_s |-> $stable(limit_o))
        else $error("limit moved with steady count");
    sync_delay_a: assert property (settled_s ##1 quiet_reg == 4'h0 |-> $stable(limit_o) [*2])
        else $error("limit reacted before synchroniser");
    flags_read_a: assert property (pready_o && !pwrite_i && paddr_i == 12'h110 && quiet_reg >= 4'h8
        |-> prdata_o == {28'h0000000, limit_o})
        else $error("status word differs from outputs");
endmodule // dual_encoder_counter_limit_switch_props

bind dual_encoder_counter_limit_switch dual_encoder_counter_limit_switch_props props_inst (
    .clk_i,
    .rst_n_i,
    .psel_i,
    .penable_i,
    .pwrite_i,
    .paddr_i,
    .prdata_o,
    .pready_o,
    .pslverr_o,
    .enc_a_i,
    .enc_b_i,
    .preset_i,
    .limit_o
);

// ---- verif/dual_encoder_counter_limit_switch_tb.sv ----
// self-checking bench for the dual encoder counter
`timescale 1ns/1ps
module dual_encoder_counter_limit_switch_tb;
    localparam logic [2:0] MODES [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5};
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h00000000;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    logic [1:0] enc_a_i;
    logic [1:0] enc_b_i;
    logic [1:0] preset_i;
    logic [3:0] limit_o;
    int fails = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [23:0] exp_c [2];
    logic [23:0] on_v [4];
    logic [23:0] off_v [4];
    logic [23:0] r;
    logic [23:0] c0;
    logic [15:0] cfg;
    logic [31:0] rd_v;
    logic err_v;

    initial begin
        forever #10 clk_i = ~clk_i;
    end

    dual_encoder_counter_limit_switch dual_encoder_counter_limit_switch_inst (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(4'hF),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .enc_a_i(enc_a_i),
        .enc_b_i(enc_b_i), .preset_i(preset_i), .limit_o(limit_o));
    enc_source_model enc_source_model_inst (
        .clk_i(clk_i), .a_o(enc_a_i), .b_o(enc_b_i), .pre_o(preset_i));

    task automatic wrap_up;
        if (fails == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // hang guard, far above the roughly 1600 cycles the run needs
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            wrap_up;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // one apb transfer; request held until ready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        // no wait count assumed; only the hang guard ends a stuck access
        do begin
            @(posedge clk_i);
        end while (pready_o !== 1'b1);
        rd_v = prdata_o;
        err_v = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        chk({31'h0, err_v}, 32'h0);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk({rd_v[31:1], rd_v[0] ^ err_v}, e);
    endtask

    // refused: error flag in top bit, data bits zero
    task automatic bad(input logic w, input logic [11:0] a);
        apb(w, a, 32'hFFFFFFFF);
        chk({err_v, rd_v[30:0]}, 32'h80000000);
    endtask

    task automatic set_cfg(input logic [15:0] c);
        cfg = c;
        wr(12'h050, {16'h0, c});
    endtask

    function automatic logic [23:0] k_of(input logic [2:0] m);
        case (m)
            3'h0, 3'h4: return 24'h1;
            3'h1, 3'h5: return 24'h2;
            3'h2: return 24'h4;
            default: return 24'h0;
        endcase
    endfunction

    task automatic run(input int ch, input int n, input logic up);
        logic [2:0] m;
        m = cfg[ch*3 +: 3];
        if (m[2]) enc_source_model_inst.pulse(ch, n, up);
        else enc_source_model_inst.quad(ch, n, up);
        if (up) exp_c[ch] = exp_c[ch] + 24'(n) * k_of(m);
        else exp_c[ch] = exp_c[ch] - 24'(n) * k_of(m);
        repeat (8) @(posedge clk_i);
    endtask

    function automatic logic [3:0] lim_exp();
        for (int i = 0; i < 4; i++) lim_exp[i] = exp_c[i/2] >= on_v[i] && exp_c[i/2] < off_v[i];
    endfunction

    initial begin
        exp_c = '{24'h0, 24'h0};
        on_v = '{24'h10, 24'h11, 24'h12, 24'h10};
        off_v = '{24'h12, 24'h13, 24'h14, 24'h10};
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        set_cfg(16'h0000);
        rd(12'h100, 32'h0);
        rd(12'h110, 32'h0);
        bad(1'b0, 12'h054);
        bad(1'b1, 12'h100);
        bad(1'b0, 12'h042);
        // every counting code, channel two one code ahead; channel two wraps below zero
        for (int i = 0; i < 5; i++) begin
            set_cfg({10'h000, MODES[(i+1)%5], MODES[i]});
            run(0, 2, 1'b1);
            run(1, 1, 1'b0);
            rd(12'h100, {8'h0, exp_c[0]});
            rd(12'h108, {8'h0, exp_c[1]});
        end
        // reserved codes hold the count
        set_cfg(16'h0033);
        run(0, 1, 1'b1);
        run(1, 1, 1'b1);
        set_cfg(16'h003F);
        run(0, 1, 1'b0);
        rd(12'h100, {8'h0, exp_c[0]});
        rd(12'h108, {8'h0, exp_c[1]});
        // preset modes, top byte of reload discarded
        wr(12'h040, 32'hAB123456);
        wr(12'h048, 32'hCD654321);
        rd(12'h040, 32'h00123456);
        for (int ch = 0; ch < 2; ch++) begin
            for (int pm = 0; pm < 4; pm++) begin
                set_cfg(16'(pm) << enc_pkg::CFG_PRE_LSB[ch]);
                r = ch ? 24'h654321 : 24'h123456;
                run(ch, 1, 1'b1);
                c0 = exp_c[ch];
                enc_source_model_inst.pre(ch, 1'b1);
                run(ch, 1, 1'b1);
                exp_c[ch] = pm == 2 ? c0 + 24'h1 : (pm == 1 ? r + 24'h1 : r);
                rd(12'h100 + 12'(8 * ch), {8'h0, exp_c[ch]});
                enc_source_model_inst.pre(ch, 1'b0);
                run(ch, 1, 1'b1);
                exp_c[ch] = pm == 1 ? r + 24'h2 : r + 24'h1;
                rd(12'h100 + 12'(8 * ch), {8'h0, exp_c[ch]});
            end
        end
        // limit windows swept by the counts
        for (int i = 0; i < 4; i++) begin
            wr(12'(16 * i), {8'hFF, on_v[i]});
            wr(12'(16 * i + 8), {8'hEE, off_v[i]});
        end
        rd(12'h000, 32'h00000010);
        wr(12'h040, 32'h0000000E);
        wr(12'h048, 32'h0000000E);
        set_cfg(16'h0140);
        enc_source_model_inst.pre(0, 1'b1);
        enc_source_model_inst.pre(1, 1'b1);
        enc_source_model_inst.pre(0, 1'b0);
        enc_source_model_inst.pre(1, 1'b0);
        exp_c = '{24'h0E, 24'h0E};
        repeat (8) @(posedge clk_i);
        for (int s = 0; s < 7; s++) begin
            chk({28'h0, limit_o}, {28'h0, lim_exp()});
            rd(12'h110, {28'h0, lim_exp()});
            run(0, 1, 1'b1);
            run(1, 1, 1'b1);
        end
        wrap_up;
    end
endmodule // dual_encoder_counter_limit_switch_tb

// ---- verif/enc_source_model.sv ----
// encoder and preset pin source standing in for the field wiring
`timescale 1ns/1ps
module enc_source_model (
    // clock
    input wire logic clk_i,
    // pins, index 0 is counter one
    output logic [1:0] a_o,
    output logic [1:0] b_o,
    output logic [1:0] pre_o
);
    // idle pins low
    initial begin
        a_o = 2'h0;
        b_o = 2'h0;
        pre_o = 2'h0;
    end

    // four clocks a level so each edge crosses the synchroniser once
    task put(input int ch, input logic a, input logic b);
        @(posedge clk_i);
        a_o[ch] <= a;
        b_o[ch] <= b;
        repeat (3) @(posedge clk_i);
    endtask

    // a leads b going up, b leads a going down
    task quad(input int ch, input int n, input logic up);
        repeat (n) for (int i = 0; i < 4; i++) begin
            if (up) put(ch, i < 2, i == 1 || i == 2);
            else put(ch, i == 1 || i == 2, i < 2);
        end
    endtask

    // b gives the way, a carries pulses; b low again after
    task pulse(input int ch, input int n, input logic up);
        put(ch, 1'b0, up);
        repeat (n) begin
            put(ch, 1'b1, up);
            put(ch, 1'b0, up);
        end
        put(ch, 1'b0, 1'b0);
    endtask

    task pre(input int ch, input logic v);
        @(posedge clk_i);
        pre_o[ch] <= v;
        repeat (3) @(posedge clk_i);
    endtask
endmodule // enc_source_model
